// File: lcdc_pkg.sv
// constants, state encodings and field defaults for the display command decoder
// assumes one 25 MHz clock and host bytes already synchronous to it
package lcdc_pkg;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 9;

    localparam logic [7:0] OP_TEST_EXIT  = 8'hf0;
    localparam logic [7:0] OP_RESET      = 8'he2;
    localparam logic [7:0] OP_NOP        = 8'he3;
    localparam logic [7:0] OP_RMW_ENTER  = 8'he0;
    localparam logic [7:0] OP_RMW_END    = 8'hee;
    localparam logic [7:0] OP_VOL_MODE   = 8'h81;

    // value, mask pairs for pattern decode
    localparam logic [7:0] PT_TEST    = 8'hf0, MK_NIB  = 8'hf0;
    localparam logic [7:0] PT_DISP    = 8'hae, MK_BIT0 = 8'hfe;
    localparam logic [7:0] PT_START   = 8'h40, MK_TOP2 = 8'hc0;
    localparam logic [7:0] PT_PAGE    = 8'hb0;
    localparam logic [7:0] PT_COL_HI  = 8'h10;
    localparam logic [7:0] PT_COL_LO  = 8'h00;
    localparam logic [7:0] PT_SEGDIR  = 8'ha0;
    localparam logic [7:0] PT_INVERT  = 8'ha6;
    localparam logic [7:0] PT_ALLON   = 8'ha4;
    localparam logic [7:0] PT_BIAS    = 8'ha2;
    localparam logic [7:0] PT_IND     = 8'hac;
    localparam logic [7:0] PT_COMDIR  = 8'hc0;
    localparam logic [7:0] PT_POWER   = 8'h28, MK_TOP5 = 8'hf8;
    localparam logic [7:0] PT_RATIO   = 8'h20;

    localparam int COMDIR_BIT = 3;
    localparam logic [7:0] COL_MAX     = 8'h83;
    localparam logic [5:0] VOLUME_RST  = 6'h20;
    localparam logic [1:0] IND_OFF     = 2'h0;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_VOL   = 6'h02,
        ST_IND   = 6'h04,
        ST_RWAIT = 6'h08,
        ST_RCAP  = 6'h10,
        ST_RDONE = 6'h20
    } lcdc_state_t;
endpackage

// File: lcdc_fifo.sv
// byte fifo between host write port and command decoder
// assumes an asynchronous active-low reset whose release is already synchronous to clk
`default_nettype none
module lcdc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [CW-1:0]               cnt;
        logic                        full;
        logic                        empty;
        logic                        avail;
    } lcdc_fifo_st_t;

    lcdc_fifo_st_t r, nxt;
    logic push, pop;

    assign push      = in_valid && !r.full;
    assign pop       = out_ready && !r.empty;
    assign in_ready  = r.avail;
    assign out_valid = !r.empty;
    assign out_data  = r.mem[r.rp];

    always_comb begin
        nxt = r;
        if (push) begin
            nxt.mem[r.wp] = in_data;
            nxt.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            nxt.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
        end
        if (push && !pop) begin
            nxt.cnt = r.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt.cnt = r.cnt - 1'b1;
        end
        nxt.full  = (nxt.cnt == CW'(DEPTH));
        nxt.empty = (nxt.cnt == '0);
        nxt.avail = (nxt.cnt != CW'(DEPTH));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r       <= '0;
            r.empty <= 1'b1;
            r.avail <= 1'b1;
        end else begin
            r <= nxt;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        r.cnt <= CW'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// File: lcdc_decoder.sv
// command and data decoder for a dot-matrix display controller
// assumes host bytes synchronous to clk, display ram with one-cycle registered read
`default_nettype none
module lcdc_decoder (
    input  wire logic        clk,
    input  wire logic        rstn,
    // host write port: bit 8 is cmd_data_select
    input  wire logic        wr_valid,
    input  wire logic        wr_cmd_data_select,
    input  wire logic [7:0]  wr_data,
    output logic             wr_ready,
    // host read port: hold rd_req until rd_valid
    input  wire logic        rd_req,
    input  wire logic        rd_cmd_data_select,
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    // display ram
    output logic             ram_we,
    output logic             ram_re,
    output logic [3:0]       ram_page,
    output logic [7:0]       ram_col,
    output logic [7:0]       ram_wdata,
    input  wire logic [7:0]  ram_rdata,
    // settings towards display and power logic
    output logic             display_on,
    output logic [5:0]       start_line,
    output logic [3:0]       page_addr,
    output logic [7:0]       col_addr,
    output logic             seg_reverse,
    output logic             pixel_invert,
    output logic             all_pixels_on,
    output logic             bias_select,
    output logic             com_reverse,
    output logic [2:0]       power_ctrl,
    output logic [2:0]       regulator_resistor_ratio,
    output logic [5:0]       contrast_volume,
    output logic             indicator_on,
    output logic [1:0]       indicator_mode,
    output logic             rmw_mode,
    output logic             test_mode,
    output logic             sleep_mode,
    output logic             standby_mode
);
    import lcdc_pkg::*;

    typedef struct packed {
        lcdc_state_t state;
        logic        disp_on;
        logic [5:0]  start;
        logic [3:0]  page;
        logic [7:0]  col;
        logic [7:0]  col_saved;
        logic        seg_rev;
        logic        invert;
        logic        all_on;
        logic        bias;
        logic        com_rev;
        logic [2:0]  power;
        logic [2:0]  ratio;
        logic [5:0]  volume;
        logic        ind_on;
        logic [1:0]  ind_mode;
        logic        rmw;
        logic        test;
        logic        force_sleep;
        logic        sleep;
        logic        standby;
        logic        we;
        logic        re;
        logic [3:0]  rpage;
        logic [7:0]  rcol;
        logic [7:0]  wdata;
        logic        rvalid;
        logic [7:0]  rdata;
    } lcdc_st_t;

    function automatic logic op_match(input logic [7:0] b, input logic [7:0] pt, input logic [7:0] mk);
        op_match = ((b & mk) == pt);
    endfunction

    function automatic logic [7:0] col_step(input logic [7:0] c);
        col_step = (c == COL_MAX) ? c : c + 8'h01;
    endfunction

    logic     rst_s1_r, rst_n;
    lcdc_st_t r, nxt;
    logic     f_valid, f_ready, f_sel, pop, cmd_pop, rd_take;
    logic [7:0] b;
    logic [8:0] f_data;
    logic       ps;

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    lcdc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_cmd_data_select, wr_data}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // decoder only stalls while serving a read
    assign f_ready = (r.state == ST_IDLE) || (r.state == ST_VOL) || (r.state == ST_IND);
    assign pop     = f_valid && f_ready;
    assign f_sel   = f_data[8];
    assign b       = f_data[7:0];
    assign cmd_pop = pop && !f_sel;
    assign rd_take = (r.state == ST_IDLE) && !f_valid && rd_req;

    always_comb begin
        nxt        = r;
        nxt.we     = 1'b0;
        nxt.re     = 1'b0;
        nxt.rvalid = 1'b0;
        ps         = 1'b0;
        unique case (r.state)
            ST_IDLE: begin
                if (pop && f_sel && !r.test) begin
                    nxt.we    = 1'b1;
                    nxt.rpage = r.page;
                    nxt.rcol  = r.col;
                    nxt.wdata = b;
                    nxt.col   = col_step(r.col);
                end else if (cmd_pop && r.test && b != OP_RESET) begin
                    // in test only the exit code is heard; reset falls through to its full decode
                    if (b == OP_TEST_EXIT) begin
                        nxt.test = 1'b0;
                    end
                end else if (cmd_pop) begin
                    if (b == OP_TEST_EXIT) begin
                        nxt.test = 1'b0;
                    end else if (op_match(b, PT_TEST, MK_NIB)) begin
                        nxt.test = 1'b1;
                    end else if (b == OP_RESET) begin
                        nxt.start   = '0;
                        nxt.page    = '0;
                        nxt.col     = '0;
                        nxt.com_rev = 1'b0;
                        nxt.bias    = 1'b0;
                        nxt.rmw     = 1'b0;
                        nxt.power   = '0;
                        nxt.ratio   = '0;
                        nxt.volume  = VOLUME_RST;
                        nxt.test    = 1'b0;
                        if (r.standby) begin
                            nxt.force_sleep = 1'b1;
                        end
                    end else if (b == OP_RMW_ENTER) begin
                        nxt.rmw       = 1'b1;
                        nxt.col_saved = r.col;
                    end else if (b == OP_RMW_END) begin
                        nxt.rmw = 1'b0;
                        nxt.col = r.col_saved;
                    end else if (b == OP_VOL_MODE) begin
                        nxt.state = ST_VOL;
                    end else if (op_match(b, PT_DISP, MK_BIT0)) begin
                        nxt.disp_on = b[0];
                    end else if (op_match(b, PT_START, MK_TOP2)) begin
                        nxt.start = b[5:0];
                    end else if (op_match(b, PT_PAGE, MK_NIB)) begin
                        nxt.page = b[3:0];
                    end else if (op_match(b, PT_COL_HI, MK_NIB)) begin
                        nxt.col[7:4] = b[3:0];
                    end else if (op_match(b, PT_COL_LO, MK_NIB)) begin
                        nxt.col[3:0] = b[3:0];
                    end else if (op_match(b, PT_SEGDIR, MK_BIT0)) begin
                        nxt.seg_rev = b[0];
                    end else if (op_match(b, PT_INVERT, MK_BIT0)) begin
                        nxt.invert = b[0];
                    end else if (op_match(b, PT_ALLON, MK_BIT0)) begin
                        nxt.all_on = b[0];
                    end else if (op_match(b, PT_BIAS, MK_BIT0)) begin
                        nxt.bias = b[0];
                    end else if (op_match(b, PT_IND, MK_BIT0)) begin
                        nxt.ind_on = b[0];
                        if (b[0]) begin
                            nxt.state = ST_IND;
                        end else begin
                            nxt.ind_mode = IND_OFF;
                        end
                    end else if (op_match(b, PT_COMDIR, MK_NIB)) begin
                        nxt.com_rev = b[COMDIR_BIT];
                    end else if (op_match(b, PT_POWER, MK_TOP5)) begin
                        nxt.power = b[2:0];
                    end else if (op_match(b, PT_RATIO, MK_TOP5)) begin
                        nxt.ratio = b[2:0];
                    end
                end else if (rd_take) begin
                    if (rd_cmd_data_select) begin
                        nxt.re    = 1'b1;
                        nxt.rpage = r.page;
                        nxt.rcol  = r.col;
                        nxt.state = ST_RWAIT;
                    end else begin
                        nxt.rdata  = {1'b0, r.seg_rev, !r.disp_on, 1'b0, 4'h0};
                        nxt.rvalid = 1'b1;
                        nxt.state  = ST_RDONE;
                    end
                end
            end
            ST_VOL: begin
                if (cmd_pop) begin
                    nxt.volume = b[5:0];
                    nxt.state  = ST_IDLE;
                end
            end
            ST_IND: begin
                if (cmd_pop) begin
                    nxt.ind_mode = b[1:0];
                    nxt.state    = ST_IDLE;
                end
            end
            ST_RWAIT: begin
                nxt.state = ST_RCAP;
            end
            ST_RCAP: begin
                nxt.rdata  = ram_rdata;
                nxt.rvalid = 1'b1;
                if (!r.rmw) begin
                    nxt.col = col_step(r.col);
                end
                nxt.state = ST_RDONE;
            end
            ST_RDONE: begin
                nxt.state = ST_IDLE;
            end
        endcase
        ps = !nxt.disp_on && nxt.all_on;
        if (!ps) begin
            nxt.force_sleep = 1'b0;
        end
        nxt.sleep   = ps && (!nxt.ind_on || nxt.force_sleep);
        nxt.standby = ps && nxt.ind_on && !nxt.force_sleep;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r        <= '0;
            r.state  <= ST_IDLE;
            r.volume <= VOLUME_RST;
        end else begin
            r <= nxt;
        end
    end

    assign ram_we                   = r.we;
    assign ram_re                   = r.re;
    assign ram_page                 = r.rpage;
    assign ram_col                  = r.rcol;
    assign ram_wdata                = r.wdata;
    assign rd_valid                 = r.rvalid;
    assign rd_data                  = r.rdata;
    assign display_on               = r.disp_on;
    assign start_line               = r.start;
    assign page_addr                = r.page;
    assign col_addr                 = r.col;
    assign seg_reverse              = r.seg_rev;
    assign pixel_invert             = r.invert;
    assign all_pixels_on            = r.all_on;
    assign bias_select              = r.bias;
    assign com_reverse              = r.com_rev;
    assign power_ctrl               = r.power;
    assign regulator_resistor_ratio = r.ratio;
    assign contrast_volume          = r.volume;
    assign indicator_on             = r.ind_on;
    assign indicator_mode           = r.ind_mode;
    assign rmw_mode                 = r.rmw;
    assign test_mode                = r.test;
    assign sleep_mode               = r.sleep;
    assign standby_mode             = r.standby;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_idle_cmd(logic [7:0] v);
        r.state == ST_IDLE && cmd_pop && b == v;
    endsequence

    sequence s_vol_pair;
        s_idle_cmd(OP_VOL_MODE) ##[1:8] (r.state == ST_VOL && cmd_pop);
    endsequence

    test_exit_a: assert property (s_idle_cmd(OP_TEST_EXIT) |=> !test_mode)
        else $error("f0 did not leave test mode");

    test_reset_a: assert property (s_idle_cmd(OP_RESET) |=> !test_mode && start_line == 6'h00)
        else $error("reset command did not clear test mode");

    disp_cmd_a: assert property (r.state == ST_IDLE && cmd_pop && !r.test && op_match(b, PT_DISP, MK_BIT0)
        |=> display_on == $past(b[0]))
        else $error("display on bit not followed");

    data_write_a: assert property (r.state == ST_IDLE && pop && f_sel && !r.test
        |=> ram_we && ram_page == $past(r.page) && ram_col == $past(r.col) && ram_wdata == $past(b))
        else $error("data byte not written at current address");

    status_read_a: assert property (rd_take && !rd_cmd_data_select |=> rd_valid && rd_data[3:0] == 4'h0)
        else $error("status low nibble not zero");

    ram_read_a: assert property (rd_take && rd_cmd_data_select |=> ram_re ##2 rd_valid)
        else $error("data read answer late");

    vol_load_a: assert property (s_vol_pair |=> r.state == ST_IDLE && contrast_volume == $past(b[5:0]))
        else $error("volume byte not taken");

    vol_enter_a: assert property ((s_idle_cmd(OP_VOL_MODE) and !r.test) |=> r.state == ST_VOL)
        else $error("volume mode not entered");

    rmw_hold_a: assert property (r.state == ST_RCAP && r.rmw |=> col_addr == $past(col_addr))
        else $error("column moved on read in rmw");

    psave_a: assert property ((sleep_mode || standby_mode) |-> !display_on && all_pixels_on
        && !(sleep_mode && standby_mode))
        else $error("power save without display off and all on");

    standby_a: assert property ((s_idle_cmd(OP_RESET) and standby_mode) |=> sleep_mode)
        else $error("reset in standby did not give sleep");
endmodule
`default_nettype wire

// File: lcdc_ram_model.sv
// display ram stand-in for the decoder's ram port
// assumes ram strobes registered by the decoder on the rising edge of clk
`default_nettype none
module lcdc_ram_model (
    input  wire logic       clk,
    input  wire logic       ram_we,
    input  wire logic       ram_re,
    input  wire logic [3:0] ram_page,
    input  wire logic [7:0] ram_col,
    input  wire logic [7:0] ram_wdata,
    output logic      [7:0] ram_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    logic [7:0] rq = 8'h5a;
    assign ram_rdata = rq;
    always @(posedge clk) begin
        if (ram_we) mem[int'({ram_page, ram_col})] = ram_wdata;
        // data valid one cycle after ram_re, toggling garbage otherwise
        if (ram_re) rq <= mem.exists(int'({ram_page, ram_col})) ? mem[int'({ram_page, ram_col})] : 8'h00;
        else rq <= ~rq;
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench: behavioural decoder model against the design
// assumes lcdc_pkg, lcdc_fifo, lcdc_decoder and lcdc_ram_model compiled first
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lcdc_pkg::*;
    typedef struct packed {
        logic dn; logic [5:0] sl; logic [3:0] pg; logic [7:0] col; logic segment_driver_output, inv, aon, bias, common_driver_output;
        logic [2:0] pwr, rat; logic [5:0] vol; logic ind, rmw, tst, slp, stb;
    } lcdc_exp_t;
    logic       clk, rstn, wr_valid, wr_cmd_data_select, wr_ready, rd_req, rd_cmd_data_select, rd_valid;
    logic       ram_we, ram_re, display_on, seg_reverse, pixel_invert, all_pixels_on, bias_select, com_reverse;
    logic       indicator_on, rmw_mode, test_mode, sleep_mode, standby_mode;
    logic [7:0] wr_data, rd_data, ram_col, ram_wdata, ram_rdata, col_addr, rc;
    logic [5:0] start_line, contrast_volume;
    logic [3:0] ram_page, page_addr;
    logic [2:0] power_ctrl, regulator_resistor_ratio;
    logic [1:0] indicator_mode, mode;
    logic [31:0] seed = 32'h00009cba;
    lcdc_exp_t  m;
    int         failures, comparisons, cycles, pend, frc, k;
    logic [7:0] mem [int];
    logic [7:0] seq [$];
    logic [7:0] pat [10] = '{PT_DISP, PT_START, PT_PAGE, PT_SEGDIR, PT_INVERT, PT_ALLON, PT_BIAS, PT_COMDIR,
                             PT_POWER, PT_RATIO};
    logic [7:0] msk [10] = '{MK_BIT0, MK_TOP2, MK_NIB, MK_BIT0, MK_BIT0, MK_BIT0, MK_BIT0, MK_NIB, MK_TOP5, MK_TOP5};

    lcdc_decoder uut (.clk(clk), .rstn(rstn), .wr_valid(wr_valid), .wr_cmd_data_select(wr_cmd_data_select),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_req(rd_req), .rd_cmd_data_select(rd_cmd_data_select),
        .rd_valid(rd_valid), .rd_data(rd_data), .ram_we(ram_we), .ram_re(ram_re), .ram_page(ram_page),
        .ram_col(ram_col), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .display_on(display_on),
        .start_line(start_line), .page_addr(page_addr), .col_addr(col_addr), .seg_reverse(seg_reverse),
        .pixel_invert(pixel_invert), .all_pixels_on(all_pixels_on), .bias_select(bias_select),
        .com_reverse(com_reverse), .power_ctrl(power_ctrl), .regulator_resistor_ratio(regulator_resistor_ratio),
        .contrast_volume(contrast_volume), .indicator_on(indicator_on), .indicator_mode(indicator_mode),
        .rmw_mode(rmw_mode), .test_mode(test_mode), .sleep_mode(sleep_mode), .standby_mode(standby_mode));
    lcdc_ram_model u_ram (.clk(clk), .ram_we(ram_we), .ram_re(ram_re), .ram_page(ram_page), .ram_col(ram_col),
        .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int ad();
        return int'({m.pg, m.col});
    endfunction
    task automatic chk(input logic [47:0] a, input logic [47:0] e);
        comparisons++;
        if (a !== e) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task automatic mdl(input logic s, input logic [7:0] d);
        if (s) begin
            if (!m.tst && pend == 0) mem[ad()] = d;
            if (!m.tst && pend == 0 && m.col < COL_MAX) m.col++;
        end else if (m.tst && d != OP_RESET) begin
            if (d == OP_TEST_EXIT) m.tst = 1'h0;
        end else if (pend != 0) begin
            if (pend == 1) m.vol = d[5:0];
            else mode = d[1:0];
            pend = 0;
        end else casez (d)
            OP_TEST_EXIT: ;
            8'hf?: m.tst = 1'h1;
            8'b1010_111?: m.dn = d[0];
            8'b01??_????: m.sl = d[5:0];
            8'hb?: m.pg = d[3:0];
            8'h1?: m.col[7:4] = d[3:0];
            8'h0?: m.col[3:0] = d[3:0];
            8'b1010_000?: m.segment_driver_output = d[0];
            8'b1010_011?: m.inv = d[0];
            8'b1010_010?: m.aon = d[0];
            8'b1010_001?: m.bias = d[0];
            8'hc?: m.common_driver_output = d[3];
            8'b0010_1???: m.pwr = d[2:0];
            8'b0010_0???: m.rat = d[2:0];
            OP_VOL_MODE: pend = 1;
            8'b1010_110?: begin
                m.ind = d[0];
                pend = d[0] ? 2 : 0;
                if (!d[0]) mode = IND_OFF;
            end
            OP_RMW_ENTER: begin
                m.rmw = 1'h1;
                rc = m.col;
            end
            OP_RMW_END: begin
                m.rmw = 1'h0;
                m.col = rc;
            end
            OP_RESET: begin
                frc = int'(frc != 0 || (!m.dn && m.aon && m.ind));
                m = '{dn: m.dn, segment_driver_output: m.segment_driver_output, inv: m.inv, aon: m.aon, ind: m.ind, vol: VOLUME_RST, default: '0};
            end
            default: ;
        endcase
        if (m.dn || !m.aon) frc = 0;
    endtask
    task automatic wr(input logic s, input logic [7:0] d);
        int n;
        n = 0;
        wr_valid <= 1'h1;
        wr_cmd_data_select <= s;
        wr_data <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wr_ready !== 1'h1 && n < 100);
        mdl(s, d);
    endtask
    task automatic settle();
        wr_valid <= 1'h0;
        repeat (6) @(posedge clk);
    endtask
    task automatic chk_all();
        m.slp = !m.dn && m.aon && (!m.ind || frc != 0);
        m.stb = !m.dn && m.aon && m.ind && frc == 0;
        chk({display_on, start_line, page_addr, col_addr, seg_reverse, pixel_invert, all_pixels_on, bias_select,
             com_reverse, power_ctrl, regulator_resistor_ratio, contrast_volume, indicator_on, rmw_mode, test_mode,
             sleep_mode, standby_mode}, m);
        chk(indicator_mode, mode);
    endtask
    task automatic cmds();
        foreach (seq[i]) wr(1'h0, seq[i]);
        settle();
        chk_all();
    endtask
    task automatic rd(input logic s);
        logic [7:0] e;
        int n;
        e = s ? (mem.exists(ad()) ? mem[ad()] : 8'h00) : {1'h0, m.segment_driver_output, !m.dn, 5'h00};
        n = 0;
        rd_req <= 1'h1;
        rd_cmd_data_select <= s;
        do begin
            @(posedge clk);
            n++;
        end while (rd_valid !== 1'h1 && n < 50);
        chk(rd_data, e);
        rd_req <= 1'h0;
        if (s && !m.rmw && m.col < COL_MAX) m.col++;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        rstn = 1'h0;
        wr_valid = 1'h0;
        wr_cmd_data_select = 1'h0;
        wr_data = 8'h00;
        rd_req = 1'h0;
        rd_cmd_data_select = 1'h0;
        mode = 2'h0;
        m = '{vol: VOLUME_RST, default: '0};
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        repeat (4) @(posedge clk);
        chk_all();
        for (int i = 0; i < 12; i++) begin
            for (int j = 0; j < 3; j++) begin
                k = int'(xs() % 10);
                wr(1'h0, (pat[k] & msk[k]) | (8'(xs()) & ~msk[k]));
            end
            settle();
            chk_all();
            rd(1'h0);
        end
        seq = '{8'hb3, 8'h18, 8'h02, OP_VOL_MODE, 8'hf5, OP_VOL_MODE, 8'(xs())};
        cmds();
        for (int j = 0; j < 5; j++) wr(1'h1, 8'(xs()));
        seq = '{8'h18, 8'h02};
        cmds();
        for (int j = 0; j < 3; j++) rd(1'h1);
        chk_all();
        for (int mm = 0; mm < 4; mm++) begin
            seq = '{8'had, (8'(xs()) & 8'hfc) | 8'(mm)};
            cmds();
        end
        seq = '{8'hac, 8'hae, 8'ha5};
        cmds();
        seq = '{8'had, 8'h03};
        cmds();
        seq = '{OP_RESET, 8'haf, 8'ha4, 8'h13, 8'h00, OP_RMW_ENTER};
        cmds();
        rd(1'h1);
        wr(1'h1, 8'(xs()));
        settle();
        rd(1'h1);
        chk_all();
        seq = '{OP_RMW_END};
        cmds();
        rd(1'h1);
        seq = '{8'hf0 | 8'(1 + xs() % 15), 8'ha7, OP_VOL_MODE};
        cmds();
        wr(1'h1, 8'h3c);
        seq = '{OP_TEST_EXIT, OP_NOP, 8'ha6, 8'h13, 8'h00};
        cmds();
        rd(1'h1);
        seq = '{8'hff, OP_RESET};
        cmds();
        seq = '{8'hf3};
        cmds();
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        m = '{vol: VOLUME_RST, default: '0};
        {frc, pend, mode} = '0;
        chk_all();
        rstn <= 1'h1;
        repeat (4) @(posedge clk);
        chk_all();
        for (int i = 0; i < 10; i++) wr(1'h1, 8'(xs()));
        chk(wr_ready, 1'h1);
        settle();
        chk_all();
        seq = '{8'h10, 8'h00};
        cmds();
        for (int i = 0; i < 10; i++) rd(1'h1);
        chk_all();
        end_sim();
    end
endmodule
`default_nettype wire
